// ===== design/ifsq_top.sv
// Sequencing, fault latch and register logic of the inrush fault sequencer
// Function
// - Pump and all gate drives except the strong switch gate pull-down stay off until the internal rail clears lockout.
// - With both supplies up, the diode gate of the lower supply is switched off.
// - From idle, load switch enables only after board-in low and on-control high for debounce.
// - Debounce completion clears fault latches and starts slow switch gate charge on the same clock edge.
// - Power-good asserts low once switch gate overdrive passes its threshold.
// - Fast diode gate pull-down engages when a supply falls below the common node.
// - On-control falling low or board removal starts normal moderate-sink turn-off.
// - A breaker trip also turns the load switch off.
// - Rail lockout turns off both diode gates and strongly pulls the switch gate.
// - Second diode disable input holds the second diode gate pulled off.
// - Board-in going low while on-control is high starts the debounce interval.
// - Any board-in bounce restarts the debounce interval from zero.
// - Board removal sinks the switch gate after a fixed delay, faults unchanged.
// - Breaker trips after sustained overcurrent; trip pulls switch gate strongly.
// - Sense above limit threshold engages current limiting; sense above breaker level charges the timer.
// - Timer crossing its upper level turns switch off and asserts fault flag.
// - After a trip the timer discharges, then counts fourteen cool-off cycles.
// - Latch-off variant restarts only once the fault was cleared by the user or the board was toggled.
// - Auto-retry variant clears the fault after cool-off and restarts charging.
// - On-control below reset level clears breaker and fault latches.
// - Power-good latches; clears on on-control low, removal, lockout or trip.
// - On-control between thresholds turns switch off; recovery skips debounce.
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`include "ifsq_defines.svh"

module ifsq_top
    import ifsq_pkg::*;
#(
    parameter logic [`IFSQ_DEB_W-1:0] DEB_CYC = `IFSQ_DEB_W'(`IFSQ_DEB_CYC)
) (
    input  wire logic        CORE_CLK,              // System clock
    input  wire logic        RST_B,                 // Async reset, low active
    input  wire logic        INTERNAL_RAIL_OK,      // Internal rail above lockout
    input  wire logic        ON_HIGH,               // On-control above rising level
    input  wire logic        ON_LOW,                // On-control below falling level
    input  wire logic        ON_RESET,              // On-control below reset level
    input  wire logic        BOARD_OUT,             // Board-inserted input high
    input  wire logic        DIODE_B_DISABLE,       // Second diode disable above level
    input  wire logic        SUPPLY_A_LOWER,        // Supply A below supply B
    input  wire logic        SUPPLY_B_LOWER,        // Supply B below supply A
    input  wire logic        SUPPLY_A_REVERSE,      // Supply A under common node
    input  wire logic        SUPPLY_B_REVERSE,      // Supply B under common node
    input  wire logic        SENSE_CB,              // Sense above breaker level
    input  wire logic        SENSE_ACL,             // Sense above limit level
    input  wire logic        TIMER_HIGH,            // Timer cap above upper level
    input  wire logic        TIMER_LOW,             // Timer cap below lower level
    input  wire logic        OVERDRIVE_OK,          // Switch gate overdrive good
    input  wire logic [3:0]  AVS_ADDRESS,           // Byte address
    input  wire logic        AVS_READ,              // Read request
    input  wire logic        AVS_WRITE,             // Write request
    input  wire logic [31:0] AVS_WRITEDATA,         // Write data
    input  wire logic [3:0]  AVS_BYTEENABLE,        // Byte lanes
    output logic      [31:0] AVS_READDATA,          // Read data
    output logic             AVS_WAITREQUEST,       // Stall
    output logic             PUMP_EN,               // Charge pump enable
    output logic             DIODE_GATE_A_EN,       // First diode gate pull-up
    output logic             DIODE_GATE_A_FAST_OFF, // First diode fast pull-down
    output logic             DIODE_GATE_B_EN,       // Second diode gate pull-up
    output logic             DIODE_GATE_B_FAST_OFF, // Second diode fast pull-down
    output logic             DIODE_GATE_B_PULLDN,   // Second diode disable sink
    output logic             SWITCH_GATE_CHARGE,    // Slow switch gate source
    output logic             SWITCH_GATE_SINK,      // Moderate switch gate sink
    output logic             SWITCH_GATE_STRONG,    // Strong switch gate pull-down
    output logic             CURRENT_LIMIT_EN,      // Current limit loop engaged
    output logic             TIMER_CHARGE,          // Timer cap charge source
    output logic             TIMER_DISCHARGE,       // Timer cap discharge sink
    output logic             FAULT_N,               // Overcurrent fault, low active
    output logic             POWER_GOOD_N           // Power good, low active
);

    ifsq_state_t                 st_ff;
    ifsq_state_t                 nxt_st;
    logic [`IFSQ_DEB_W-1:0]      deb_cnt_ff;
    logic [`IFSQ_REM_W-1:0]      rem_cnt_ff;
    logic [`IFSQ_COOL_W-1:0]     cool_cnt_ff;
    logic                        fault_ff;
    logic                        nxt_fault;
    logic                        pg_ff;
    logic                        nxt_pg;
    logic                        toggled_ff;
    logic                        retry_ff;
    logic                        trip;
    logic                        deb_done;
    logic                        rem_done;
    logic                        cool_end;
    logic                        cool_st;
    logic                        bus_req;

    // Event decodes
    assign trip     = (st_ff == IFSQ_ON || st_ff == IFSQ_REMOVE) && TIMER_HIGH;
    assign deb_done = st_ff == IFSQ_DEBOUNCE && !BOARD_OUT && !ON_LOW
                      && deb_cnt_ff == DEB_CYC - `IFSQ_DEB_W'(1);
    assign rem_done = rem_cnt_ff == `IFSQ_REM_W'(`IFSQ_REM_CYC - 1);
    assign cool_end = st_ff == IFSQ_COOL_DCH && TIMER_LOW
                      && cool_cnt_ff == `IFSQ_COOL_LAST;
    assign cool_st  = st_ff == IFSQ_COOL_DIS || st_ff == IFSQ_COOL_CHG
                      || st_ff == IFSQ_COOL_DCH;
    assign bus_req  = AVS_READ || AVS_WRITE;

    // Next state of the switch sequencer
    always_comb begin
        nxt_st = st_ff;
        if (!INTERNAL_RAIL_OK) begin
            nxt_st = IFSQ_IDLE;
        end else if (ON_RESET && !cool_st && !trip) begin
            nxt_st = IFSQ_IDLE;
        end else begin
            unique case (st_ff)
                IFSQ_IDLE: begin
                    if (ON_HIGH && !ON_LOW && !BOARD_OUT) begin
                        nxt_st = IFSQ_DEBOUNCE;
                    end
                end
                IFSQ_DEBOUNCE: begin
                    if (BOARD_OUT || ON_LOW) begin
                        nxt_st = IFSQ_IDLE;
                    end else if (deb_done) begin
                        nxt_st = IFSQ_ON;
                    end
                end
                IFSQ_ON: begin
                    if (trip) begin
                        nxt_st = IFSQ_COOL_DIS;
                    end else if (BOARD_OUT) begin
                        nxt_st = IFSQ_REMOVE;
                    end else if (ON_LOW) begin
                        nxt_st = IFSQ_UVOFF;
                    end
                end
                IFSQ_UVOFF: begin
                    if (BOARD_OUT) begin
                        nxt_st = IFSQ_IDLE;
                    end else if (ON_HIGH) begin
                        nxt_st = IFSQ_ON;
                    end
                end
                IFSQ_REMOVE: begin
                    if (trip) begin
                        nxt_st = IFSQ_COOL_DIS;
                    end else if (rem_done) begin
                        nxt_st = IFSQ_IDLE;
                    end
                end
                IFSQ_COOL_DIS: begin
                    if (TIMER_LOW) begin
                        nxt_st = IFSQ_COOL_CHG;
                    end
                end
                IFSQ_COOL_CHG: begin
                    if (TIMER_HIGH) begin
                        nxt_st = IFSQ_COOL_DCH;
                    end
                end
                IFSQ_COOL_DCH: begin
                    if (cool_end && retry_ff) begin
                        nxt_st = IFSQ_ON;
                    end else if (cool_end && (!fault_ff || toggled_ff)) begin
                        nxt_st = IFSQ_IDLE;
                    end else if (TIMER_LOW) begin
                        nxt_st = IFSQ_COOL_CHG;
                    end
                end
                default: begin
                    nxt_st = IFSQ_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_ff <= IFSQ_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Debounce counter, cleared whenever debounce is left
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            deb_cnt_ff <= '0;
        end else if (nxt_st != IFSQ_DEBOUNCE || st_ff != IFSQ_DEBOUNCE) begin
            deb_cnt_ff <= '0;
        end else begin
            deb_cnt_ff <= deb_cnt_ff + `IFSQ_DEB_W'(1);
        end
    end

    // Removal delay counter
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rem_cnt_ff <= '0;
        end else if (st_ff != IFSQ_REMOVE || nxt_st != IFSQ_REMOVE) begin
            rem_cnt_ff <= '0;
        end else begin
            rem_cnt_ff <= rem_cnt_ff + `IFSQ_REM_W'(1);
        end
    end

    // Cool-off cycle counter
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cool_cnt_ff <= '0;
        end else if (!cool_st || st_ff == IFSQ_COOL_DIS) begin
            cool_cnt_ff <= '0;
        end else if (st_ff == IFSQ_COOL_DCH && TIMER_LOW) begin
            if (cool_end) begin
                cool_cnt_ff <= '0;
            end else begin
                cool_cnt_ff <= cool_cnt_ff + `IFSQ_COOL_W'(1);
            end
        end
    end

    // Fault latch; a trip wins over any clear in the same cycle except rail lockout
    always_comb begin
        nxt_fault = fault_ff;
        if (!INTERNAL_RAIL_OK) begin
            nxt_fault = 1'b0;
        end else if (trip) begin
            nxt_fault = 1'b1;
        end else if (ON_RESET) begin
            nxt_fault = 1'b0;
        end else if (deb_done) begin
            nxt_fault = 1'b0;
        end else if (cool_end && retry_ff) begin
            nxt_fault = 1'b0;
        end
    end

    // Power-good latch
    always_comb begin
        nxt_pg = pg_ff;
        if (!INTERNAL_RAIL_OK || ON_LOW || ON_RESET || BOARD_OUT || trip) begin
            nxt_pg = 1'b0;
        end else if (st_ff == IFSQ_ON && nxt_st == IFSQ_ON && OVERDRIVE_OK) begin
            nxt_pg = 1'b1;
        end
    end

    // Fault and power-good registers and flags
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            fault_ff     <= 1'b0;
            pg_ff        <= 1'b0;
            FAULT_N      <= 1'b1;
            POWER_GOOD_N <= 1'b1;
        end else begin
            fault_ff     <= nxt_fault;
            pg_ff        <= nxt_pg;
            FAULT_N      <= !nxt_fault;
            POWER_GOOD_N <= !nxt_pg;
        end
    end

    // Board toggle seen while a fault is latched
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            toggled_ff <= 1'b0;
        end else if (!INTERNAL_RAIL_OK) begin
            toggled_ff <= 1'b0;
        end else if (BOARD_OUT && fault_ff) begin
            toggled_ff <= 1'b1;
        end else if (deb_done) begin
            toggled_ff <= 1'b0;
        end
    end

    // Diode gate drives and charge pump
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PUMP_EN               <= 1'b0;
            DIODE_GATE_A_EN       <= 1'b0;
            DIODE_GATE_A_FAST_OFF <= 1'b0;
            DIODE_GATE_B_EN       <= 1'b0;
            DIODE_GATE_B_FAST_OFF <= 1'b0;
            DIODE_GATE_B_PULLDN   <= 1'b0;
        end else begin
            PUMP_EN               <= INTERNAL_RAIL_OK;
            DIODE_GATE_A_EN       <= INTERNAL_RAIL_OK && !SUPPLY_A_LOWER
                                     && !SUPPLY_A_REVERSE;
            DIODE_GATE_A_FAST_OFF <= INTERNAL_RAIL_OK && SUPPLY_A_REVERSE;
            DIODE_GATE_B_EN       <= INTERNAL_RAIL_OK && !SUPPLY_B_LOWER
                                     && !SUPPLY_B_REVERSE && !DIODE_B_DISABLE;
            DIODE_GATE_B_FAST_OFF <= INTERNAL_RAIL_OK && SUPPLY_B_REVERSE;
            DIODE_GATE_B_PULLDN   <= INTERNAL_RAIL_OK && DIODE_B_DISABLE;
        end
    end

    // Switch gate, current limit and timer drives
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            SWITCH_GATE_CHARGE <= 1'b0;
            SWITCH_GATE_SINK   <= 1'b0;
            SWITCH_GATE_STRONG <= 1'b1;
            CURRENT_LIMIT_EN   <= 1'b0;
            TIMER_CHARGE       <= 1'b0;
            TIMER_DISCHARGE    <= 1'b0;
        end else begin
            SWITCH_GATE_CHARGE <= nxt_st == IFSQ_ON || nxt_st == IFSQ_REMOVE;
            SWITCH_GATE_SINK   <= INTERNAL_RAIL_OK && nxt_st != IFSQ_ON
                                  && nxt_st != IFSQ_REMOVE;
            SWITCH_GATE_STRONG <= !INTERNAL_RAIL_OK || nxt_st == IFSQ_COOL_DIS
                                  || nxt_st == IFSQ_COOL_CHG
                                  || nxt_st == IFSQ_COOL_DCH;
            CURRENT_LIMIT_EN   <= SENSE_ACL && (nxt_st == IFSQ_ON
                                  || nxt_st == IFSQ_REMOVE);
            TIMER_CHARGE       <= nxt_st == IFSQ_COOL_CHG || (SENSE_CB
                                  && (nxt_st == IFSQ_ON || nxt_st == IFSQ_REMOVE));
            TIMER_DISCHARGE    <= INTERNAL_RAIL_OK && nxt_st != IFSQ_COOL_CHG
                                  && !(SENSE_CB && (nxt_st == IFSQ_ON
                                  || nxt_st == IFSQ_REMOVE));
        end
    end

    // Control register write
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            retry_ff <= `IFSQ_CTRL_RST;
        end else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
                     && AVS_ADDRESS[3:2] == `IFSQ_REG_CTRL) begin
            retry_ff <= AVS_WRITEDATA[`IFSQ_CTRL_RETRY];
        end
    end

    // Bus answer: one wait cycle, then read data with waitrequest low
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= '0;
        end else if (bus_req && AVS_WAITREQUEST) begin
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA    <= '0;
            if (AVS_READ) begin
                unique case (AVS_ADDRESS[3:2])
                    `IFSQ_REG_CTRL: begin
                        AVS_READDATA[`IFSQ_CTRL_RETRY] <= retry_ff;
                    end
                    `IFSQ_REG_STATUS: begin
                        AVS_READDATA[`IFSQ_ST_STATE_LO +: 4]             <= st_ff;
                        AVS_READDATA[`IFSQ_ST_FAULT]                     <= fault_ff;
                        AVS_READDATA[`IFSQ_ST_PGOOD]                     <= pg_ff;
                        AVS_READDATA[`IFSQ_ST_COOL_LO +: `IFSQ_COOL_W]   <= cool_cnt_ff;
                        AVS_READDATA[`IFSQ_ST_TOGGLE]                    <= toggled_ff;
                    end
                    default: begin
                        AVS_READDATA <= '0;
                    end
                endcase
            end
        end else begin
            AVS_WAITREQUEST <= 1'b1;
        end
    end

    // Checks on the sequencing outputs
    a_uvlo_gates_off: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        !INTERNAL_RAIL_OK |=> !PUMP_EN && !SWITCH_GATE_CHARGE
        && !DIODE_GATE_A_EN && !DIODE_GATE_B_EN)
        else $error("gate drive active during lockout");
    a_uvlo_strong_pull: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        !INTERNAL_RAIL_OK |=> SWITCH_GATE_STRONG && FAULT_N && POWER_GOOD_N)
        else $error("lockout did not pull switch gate or clear flags");
    a_lower_diode_off: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        INTERNAL_RAIL_OK && SUPPLY_A_LOWER |=> !DIODE_GATE_A_EN)
        else $error("lower supply diode left on");
    a_reverse_fast: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        INTERNAL_RAIL_OK && SUPPLY_B_REVERSE |=> DIODE_GATE_B_FAST_OFF && !DIODE_GATE_B_EN)
        else $error("reverse current not cut");
    a_diode_b_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        INTERNAL_RAIL_OK && DIODE_B_DISABLE [*2] |-> DIODE_GATE_B_PULLDN && !DIODE_GATE_B_EN)
        else $error("second diode not held off");
    a_bounce_restart: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        st_ff == IFSQ_DEBOUNCE && BOARD_OUT |=> deb_cnt_ff == '0 && !SWITCH_GATE_CHARGE)
        else $error("debounce not restarted");
    a_charge_after_deb: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        $rose(SWITCH_GATE_CHARGE) |-> $past(st_ff) != IFSQ_IDLE && $past(st_ff) != IFSQ_UVOFF
        || $past(ON_HIGH))
        else $error("switch charged without debounce");
    a_trip_fault: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        INTERNAL_RAIL_OK && st_ff == IFSQ_ON && TIMER_HIGH |=> !FAULT_N && POWER_GOOD_N
        && SWITCH_GATE_STRONG && !SWITCH_GATE_CHARGE)
        else $error("trip did not turn switch off");
    a_pgood_set: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        INTERNAL_RAIL_OK && st_ff == IFSQ_ON && OVERDRIVE_OK && !TIMER_HIGH
        && !ON_LOW && !ON_RESET && !BOARD_OUT |=> !POWER_GOOD_N)
        else $error("power good not asserted");
    a_removal_delay: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        INTERNAL_RAIL_OK && st_ff == IFSQ_ON && BOARD_OUT && !TIMER_HIGH && !ON_RESET
        |=> SWITCH_GATE_CHARGE && !SWITCH_GATE_SINK && $stable(FAULT_N))
        else $error("removal turned switch off without delay");
    a_auto_retry: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        INTERNAL_RAIL_OK && cool_end && retry_ff |=> FAULT_N && SWITCH_GATE_CHARGE)
        else $error("auto retry did not restart");
    a_reset_clears: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        INTERNAL_RAIL_OK && ON_RESET && !trip |=> FAULT_N && POWER_GOOD_N)
        else $error("reset level did not clear latches");

endmodule : ifsq_top

// ===== shared/ifsq_defines.svh
// Timing, register map and field constants for the inrush fault sequencer
`ifndef IFSQ_DEFINES_SVH
`define IFSQ_DEFINES_SVH

// System clock period in ns (125 MHz)
`define IFSQ_CLK_NS       8
// Contact debounce interval in ms
`define IFSQ_DEB_MS       100
// Board removal turn-off delay in us
`define IFSQ_REM_US       20
// Least times round up to whole cycles
`define IFSQ_DEB_CYC      (((`IFSQ_DEB_MS * 1000000) + `IFSQ_CLK_NS - 1) / `IFSQ_CLK_NS)
`define IFSQ_REM_CYC      (((`IFSQ_REM_US * 1000) + `IFSQ_CLK_NS - 1) / `IFSQ_CLK_NS)
// Counter widths
`define IFSQ_DEB_W        24
`define IFSQ_REM_W        12
`define IFSQ_COOL_W       4
// Cool-off length in timer cycles, and the index of the last one
`define IFSQ_COOL_CYCLES  14
`define IFSQ_COOL_LAST    4'hd

// Register word offsets (byte address bits 3:2)
`define IFSQ_REG_CTRL     2'h0
`define IFSQ_REG_STATUS   2'h1
// Control fields
`define IFSQ_CTRL_RETRY   0
`define IFSQ_CTRL_RST     1'h0
// Status fields
`define IFSQ_ST_STATE_LO  0
`define IFSQ_ST_FAULT     4
`define IFSQ_ST_PGOOD     5
`define IFSQ_ST_COOL_LO   6
`define IFSQ_ST_TOGGLE    10

`endif

// ===== shared/ifsq_pkg.sv
// Types shared by the inrush fault sequencer
package ifsq_pkg;

    // Switch sequencing states
    typedef enum logic [3:0] {
        IFSQ_IDLE     = 4'h0,
        IFSQ_DEBOUNCE = 4'h1,
        IFSQ_ON       = 4'h2,
        IFSQ_UVOFF    = 4'h3,
        IFSQ_REMOVE   = 4'h4,
        IFSQ_COOL_DIS = 4'h5,
        IFSQ_COOL_CHG = 4'h6,
        IFSQ_COOL_DCH = 4'h7
    } ifsq_state_t;

endpackage : ifsq_pkg

// ===== verif/inrush_fault_sequencer_bench.sv
// Self-checking bench for the inrush fault sequencer
`timescale 1ns/1ns
module inrush_fault_sequencer_bench;
    localparam int DEB = 16;
    logic        clk = 1'h0, rst_b = 1'h0, rail = 1'h0, on_h = 1'h0, on_l = 1'h0, brd = 1'h0;
    logic        current_limit_loop = 1'h0, t_hi = 1'h0, t_lo = 1'h0, ovd = 1'h0, rd = 1'h0, wr = 1'h0;
    logic        on_rst = 1'h0;
    logic [4:0]  dio = 5'h00;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wd = 32'h0, q;
    wire  [31:0] rdat;
    wire  [4:0]  dg, sw;
    wire         wq, pump, clim, tch, tdc;
    int          error_cnt = 0, n_compared = 0, cyc = 0;
    // Shortened debounce count keeps the run brief
    ifsq_top #(.DEB_CYC(24'h10)) i_dut (
        .CORE_CLK(clk), .RST_B(rst_b), .INTERNAL_RAIL_OK(rail), .ON_HIGH(on_h), .ON_LOW(on_l),
        .ON_RESET(on_rst), .BOARD_OUT(brd), .DIODE_B_DISABLE(dio[0]), .SUPPLY_A_LOWER(dio[4]),
        .SUPPLY_B_LOWER(dio[3]), .SUPPLY_A_REVERSE(dio[2]), .SUPPLY_B_REVERSE(dio[1]),
        .SENSE_CB(current_limit_loop), .SENSE_ACL(current_limit_loop), .TIMER_HIGH(t_hi), .TIMER_LOW(t_lo), .OVERDRIVE_OK(ovd),
        .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq), .PUMP_EN(pump),
        .DIODE_GATE_A_EN(dg[4]), .DIODE_GATE_A_FAST_OFF(dg[3]), .DIODE_GATE_B_EN(dg[2]),
        .DIODE_GATE_B_FAST_OFF(dg[1]), .DIODE_GATE_B_PULLDN(dg[0]), .SWITCH_GATE_CHARGE(sw[4]),
        .SWITCH_GATE_SINK(sw[3]), .SWITCH_GATE_STRONG(sw[2]), .CURRENT_LIMIT_EN(clim),
        .TIMER_CHARGE(tch), .TIMER_DISCHARGE(tdc), .FAULT_N(sw[1]), .POWER_GOOD_N(sw[0])
    );
    // Clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    task finish_test;
        if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    // Wait edges, then look at settled outputs
    task step(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : step
    // Timer rounds down to low then up to high, fault flag expected at f
    task cool(input int n, input logic f);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            t_hi <= 1'h0;
            t_lo <= 1'h1;
            step(2);
            chk("cool_fault", sw[1], f);
            @(posedge clk);
            t_lo <= 1'h0;
            t_hi <= 1'h1;
            step(2);
        end
    endtask : cool
    // Avalon-MM access held until waitrequest is sampled low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (wq !== 1'h0);
        q = rdat;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask : bus
    // Lockout holds pump off, then diode gate table with rail up
    task t_diodes;
        logic [4:0] drv [3];
        logic [4:0] dexp [3];
        drv = '{5'h15, 5'h0a, 5'h00};
        dexp = '{5'h09, 5'h12, 5'h14};
        step(2);
        chk("pump_off", pump, 1'h0);
        chk("strong_uv", sw[2], 1'h1);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            rail <= 1'h1;
            dio <= drv[i];
            step(1);
            chk("pump_on", pump, 1'h1);
            chk("diode_gates", dg, dexp[i]);
        end
    endtask : t_diodes
    // Debounce with a contact bounce, then power good and limiting
    task t_start;
        @(posedge clk);
        on_h <= 1'h1;
        step(DEB - 6);
        @(posedge clk);
        brd <= 1'h1;
        @(posedge clk);
        brd <= 1'h0;
        step(DEB - 4);
        chk("deb_restart", sw[4], 1'h0);
        step(8);
        chk("charge", sw, 5'h13);
        @(posedge clk);
        ovd <= 1'h1;
        current_limit_loop <= 1'h1;
        step(1);
        chk("pgood", sw[0], 1'h0);
        chk("limit", {clim, tch}, 2'h3);
    endtask : t_start
    // Registers: retry mode, status, unmapped place
    task t_regs;
        bus(1'h1, 4'h0, 32'h1);
        bus(1'h0, 4'h0, 32'h0);
        chk("ctrl", q, 32'h1);
        bus(1'h0, 4'h4, 32'h0);
        chk("state_on", q[3:0], 4'h2);
        bus(1'h0, 4'hc, 32'h0);
        chk("unmapped", q, 32'h0);
    endtask : t_regs
    // Breaker trip, fourteen cool-off cycles, automatic retry
    task t_trip;
        @(posedge clk);
        t_hi <= 1'h1;
        ovd <= 1'h0;
        current_limit_loop <= 1'h0;
        step(1);
        chk("trip", sw, 5'h0d);
        chk("tmr_dis", tdc, 1'h1);
        cool(14, 1'h0);
        @(posedge clk);
        t_hi <= 1'h0;
        t_lo <= 1'h1;
        step(2);
        chk("retry", sw[4:1], 4'h9);
    endtask : t_trip
    // Undervoltage dip, board removal delay, rail lockout
    task t_off;
        @(posedge clk);
        t_lo <= 1'h0;
        on_l <= 1'h1;
        on_h <= 1'h0;
        step(1);
        chk("uv_sink", sw[3], 1'h1);
        @(posedge clk);
        on_l <= 1'h0;
        on_h <= 1'h1;
        step(1);
        chk("uv_back", sw[4:3], 2'h2);
        @(posedge clk);
        brd <= 1'h1;
        step(2500);
        chk("rem_wait", sw[4:3], 2'h2);
        step(1);
        chk("rem_sink", sw[3:1], 3'h5);
        @(posedge clk);
        rail <= 1'h0;
        step(1);
        chk("lockout", {pump, dg[4], dg[2], sw[2]}, 4'h1);
    endtask : t_off
    // Latch-off: no restart until the reset level clears the fault
    task t_latch;
        @(posedge clk);
        rail <= 1'h1;
        brd <= 1'h0;
        bus(1'h1, 4'h0, 32'h0);
        step(DEB + 2);
        chk("latch_on", sw[4], 1'h1);
        @(posedge clk);
        t_hi <= 1'h1;
        step(1);
        chk("latch_trip", sw[1], 1'h0);
        cool(15, 1'h0);
        chk("latch_hold", sw[4], 1'h0);
        @(posedge clk);
        on_rst <= 1'h1;
        step(1);
        chk("reset_clr", sw[1:0], 2'h3);
        @(posedge clk);
        on_rst <= 1'h0;
        cool(14, 1'h1);
        chk("redebounce", sw[4], 1'h0);
        @(posedge clk);
        t_hi <= 1'h0;
        step(DEB);
        chk("latch_restart", sw[4:1], 4'h9);
    endtask : t_latch
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        t_diodes();
        t_start();
        t_regs();
        t_trip();
        t_off();
        t_latch();
        finish_test();
    end
endmodule : inrush_fault_sequencer_bench
